// file: hw/instr_format_addr_decoder.sv
/*
 Instruction format and operand address decoder with execution timer.
 Assumes memory, register file and datapath share this clock and
 answer in the same domain; the decoder holds mem_req until mem_ack.
*/
`timescale 1ns/1ps
module instr_format_addr_decoder #(
   parameter int FILE_MAX = instr_decode_pkg::MAX_WORDS
) (
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire logic                    start,
   input  wire logic                    pc_load,
   input  wire instr_decode_pkg::word_t pc_load_val,
   input  wire logic                    mem_ack,
   input  wire instr_decode_pkg::word_t mem_rdata,
   input  wire instr_decode_pkg::word_t reg_rd_data,
   input  wire logic                    result_nz,
   input  wire instr_decode_pkg::word_t branch_target,
   input  wire instr_decode_pkg::nib_t  file_words,
   output logic                         mem_req,
   output instr_decode_pkg::word_t      mem_addr_q,
   output instr_decode_pkg::nib_t       reg_rd_sel_q,
   output logic                         busy,
   output logic                         done,
   output logic [7:0]                   opcode_q,
   output instr_decode_pkg::nib_t       field_a_q,
   output instr_decode_pkg::nib_t       field_b_q,
   output instr_decode_pkg::word_t      oper_addr_q,
   output instr_decode_pkg::word_t      pc_q,
   output instr_decode_pkg::nib_t       word_count_q,
   output logic [1:0]                   byte_en_q,
   output logic                         illegal_q,
   output logic                         wr_reg_q,
   output logic                         wr_mem_q,
   output logic                         cond_upd_q,
   output logic                         clear_ovf_q,
   output logic                         branch_taken_q
);
   import instr_decode_pkg::*;

   generate
      if (FILE_MAX < 1 || FILE_MAX > MAX_WORDS) begin : g_bad
         $error("FILE_MAX must lie in 1..8");
      end
   endgenerate

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_DEC   = 3'b010,
      S_EXT   = 3'b011,
      S_IND   = 3'b100,
      S_EXEC  = 3'b101,
      S_DONE  = 3'b110
   } state_t;

   state_t      state_q;
   logic [15:0] elapsed_q;
   cls_t        cls;
   form_t       frm;
   form_t       in_frm;
   logic [6:0]  lk;
   logic        legal, is_dir, is_br, is_file;
   logic [3:0]  words;
   logic [5:0]  extra;
   logic [6:0]  need_steps;
   logic [15:0] need_cyc;
   logic        fetch_ok, ext_ok, ind_ok, fin, dec_go;
   logic [2:0]  idx_sel;
   word_t       idx_sum;

   // Time table per class and form; bit 6 marks a legal pairing
   function automatic logic [6:0] lookup(input cls_t c, input form_t f);
      logic       short_f;
      logic [5:0] s;
      logic       ok;
      short_f = (f == F_SDS) || (f == F_SIX);
      s  = 6'h00;
      ok = 1'b1;
      case (c)
         C_LOAD, C_STORE: begin
            if (f == F_DIR) s = to_steps(T_2400_NS);
            else if (f == F_IMM) s = to_steps(T_1600_NS);
            else if (short_f) s = to_steps(T_1870_NS);
            else ok = 1'b0;
         end
         C_LFILE: begin
            if (f == F_DIR) s = to_steps(T_2930_NS);
            else if (short_f) s = to_steps(T_2400_NS);
            else ok = 1'b0;
         end
         C_SFILE: begin
            if (f == F_DIR || short_f) s = to_steps(T_1870_NS);
            else ok = 1'b0;
         end
         C_LBYTE: begin
            if (f == F_SIX) s = to_steps(T_2130_NS);
            else ok = 1'b0;
         end
         C_SBYTE: begin
            if (f == F_SIX) s = to_steps(T_2400_NS);
            else ok = 1'b0;
         end
         C_MOVE, C_NEG: begin
            if (f == F_RR) s = to_steps(T_0800_NS);
            else if (f == F_RRB) s = to_steps(T_1600_NS);
            else ok = 1'b0;
         end
         C_ADDM: begin
            if (f == F_DIR) s = to_steps(T_2400_NS);
            else if (f == F_IMM) s = to_steps(T_1600_NS);
            else if (short_f) s = to_steps(T_1870_NS);
            else if (f == F_RR) s = to_steps(T_0800_NS);
            else if (f == F_RRB) s = to_steps(T_1600_NS);
            else ok = 1'b0;
         end
         C_ADD2M: begin
            if (f == F_DIR) s = to_steps(T_3470_NS);
            else if (short_f) s = to_steps(T_2930_NS);
            else if (f == F_DIRB) s = to_steps(T_4270_NS);
            else if (f == F_SDSB || f == F_SIXB) s = to_steps(T_3830_NS);
            else ok = 1'b0;
         end
         C_DADD: begin
            if (f == F_RR) s = to_steps(T_1600_NS);
            else ok = 1'b0;
         end
         C_SUB: begin
            if (f == F_DIR) s = to_steps(T_2400_NS);
            else if (f == F_IMM || f == F_SDS) s = to_steps(T_1600_NS);
            else if (f == F_SIX) s = to_steps(T_1870_NS);
            else if (f == F_RR) s = to_steps(T_0800_NS);
            else if (f == F_RRB) s = to_steps(T_1600_NS);
            else ok = 1'b0;
         end
         C_MUL: begin
            if (f == F_DIR) s = to_steps(T_7200_NS);
            else if (short_f) s = to_steps(T_6670_NS);
            else if (f == F_RR) s = to_steps(T_6130_NS);
            else ok = 1'b0;
         end
         C_DIV: begin
            if (f == F_DIR) s = to_steps(T_9870_NS);
            else if (short_f) s = to_steps(T_9330_NS);
            else if (f == F_RR) s = to_steps(T_8800_NS);
            else ok = 1'b0;
         end
         C_CMP: begin
            if (f == F_DIR) s = to_steps(T_4800_NS);
            else if (short_f) s = to_steps(T_4270_NS);
            else ok = 1'b0;
         end
         C_MOVCO: begin
            if (f == F_RR) s = to_steps(T_0800_NS);
            else ok = 1'b0;
         end
         default: ok = 1'b0;
      endcase
      return {ok, s};
   endfunction

   assign cls     = cls_t'(opcode_q[7:4]);
   assign frm     = form_t'(opcode_q[3:0]);
   assign in_frm  = form_t'(mem_rdata[11:8]);
   assign lk      = lookup(cls, frm);
   assign legal   = lk[6];
   assign is_dir  = (frm == F_DIR) || (frm == F_DIRB);
   assign is_br   = (frm == F_RRB) || (frm == F_DIRB) ||
                    (frm == F_SDSB) || (frm == F_SIXB);
   assign is_file = (cls == C_LFILE) || (cls == C_SFILE);
   assign idx_sel = field_b_q[2:0];

   // Word counts outside 1..FILE_MAX are clamped rather than refused
   assign words = (file_words == 4'h0) ? 4'h1 :
                  (file_words > 4'(FILE_MAX)) ? 4'(FILE_MAX) : file_words;
   assign extra = is_file ?
                  6'((words - 4'h1) * to_steps(T_WORD_NS)) : 6'h00;
   assign need_steps = {1'b0, lk[5:0]} + {1'b0, extra};
   assign need_cyc   = 16'(need_steps * STEP_CYC);

   assign fetch_ok = (state_q == S_FETCH) && mem_ack;
   assign ext_ok   = (state_q == S_EXT) && mem_ack;
   assign ind_ok   = (state_q == S_IND) && mem_ack;
   assign dec_go   = (state_q == S_DEC) && legal;
   // Finish only once the step count is spent and addressing is over
   assign fin      = (state_q == S_EXEC) && (elapsed_q >= need_cyc - 16'h0001);

   // Index zero adds nothing
   assign idx_sum = mem_rdata + ((idx_sel != 3'h0) ? reg_rd_data : 16'h0000);

   assign mem_req = (state_q == S_FETCH) || (state_q == S_EXT) || (state_q == S_IND);
   assign busy    = (state_q != S_IDLE);
   assign done    = (state_q == S_DONE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE:  if (start) state_q <= S_FETCH;
            S_FETCH: if (mem_ack) state_q <= S_DEC;
            S_DEC: begin
               if (!legal) state_q <= S_DONE;
               else if (is_dir) state_q <= S_EXT;
               else state_q <= S_EXEC;
            end
            S_EXT:   if (mem_ack) state_q <= field_b_q[3] ? S_IND : S_EXEC;
            S_IND:   if (mem_ack) state_q <= S_EXEC;
            S_EXEC:  if (fin) state_q <= S_DONE;
            S_DONE:  state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_q <= PC_RST;
      end else if (state_q == S_IDLE && pc_load) begin
         pc_q <= pc_load_val;
      end else if (fetch_ok || ext_ok) begin
         pc_q <= pc_q + 16'h0001;
      end else if (dec_go && frm == F_IMM) begin
         pc_q <= pc_q + 16'h0001;
      end else if (fin && is_br && result_nz) begin
         pc_q <= branch_target;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         elapsed_q <= 16'h0000;
      end else if (state_q == S_IDLE) begin
         elapsed_q <= start ? 16'h0001 : 16'h0000;
      end else if (elapsed_q != 16'hFFFF) begin
         elapsed_q <= elapsed_q + 16'h0001;
      end
   end

   // Fields, register selection and operand address
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opcode_q     <= 8'h00;
         field_a_q    <= 4'h0;
         field_b_q    <= 4'h0;
         mem_addr_q   <= 16'h0000;
         reg_rd_sel_q <= 4'h0;
         oper_addr_q  <= 16'h0000;
         byte_en_q    <= 2'h3;
         word_count_q <= 4'h0;
      end else begin
         if (state_q == S_IDLE && start) mem_addr_q <= pc_q;
         if (fetch_ok) begin
            opcode_q  <= mem_rdata[15:8];
            field_a_q <= mem_rdata[7:4];
            field_b_q <= mem_rdata[3:0];
            byte_en_q <= 2'h3;
            if (in_frm == F_SDS || in_frm == F_SDSB) reg_rd_sel_q <= SDISP_REG;
            else reg_rd_sel_q <= mem_rdata[3:0];
         end
         if (dec_go) begin
            word_count_q <= is_file ? words : 4'h1;
            case (frm)
               F_DIR, F_DIRB: begin
                  mem_addr_q   <= pc_q;
                  reg_rd_sel_q <= {1'b0, idx_sel};
               end
               F_IMM: oper_addr_q <= pc_q;
               F_SDS, F_SDSB: oper_addr_q <= reg_rd_data + {12'h000, field_b_q};
               F_SIX, F_SIXB: begin
                  if (cls == C_LBYTE || cls == C_SBYTE) begin
                     // Register holds a byte address; bit 0 picks the lane
                     oper_addr_q <= {1'b0, reg_rd_data[15:1]};
                     byte_en_q   <= reg_rd_data[0] ? 2'h1 : 2'h2;
                  end else begin
                     oper_addr_q <= reg_rd_data;
                  end
               end
               default: oper_addr_q <= oper_addr_q;
            endcase
         end
         if (ext_ok) begin
            // Indexing is applied before any indirection
            oper_addr_q <= idx_sum;
            mem_addr_q  <= idx_sum;
         end
         if (ind_ok) oper_addr_q <= mem_rdata;
      end
   end

   // Completion qualifiers, each a pulse alongside done
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         illegal_q      <= 1'b0;
         wr_reg_q       <= 1'b0;
         wr_mem_q       <= 1'b0;
         cond_upd_q     <= 1'b0;
         clear_ovf_q    <= 1'b0;
         branch_taken_q <= 1'b0;
      end else begin
         illegal_q      <= (state_q == S_DEC) && !legal;
         wr_reg_q       <= fin && !(cls inside {C_STORE, C_SFILE, C_SBYTE, C_ADD2M, C_CMP});
         wr_mem_q       <= fin && (cls inside {C_STORE, C_SFILE, C_SBYTE, C_ADD2M});
         cond_upd_q     <= fin && (cls == C_CMP);
         clear_ovf_q    <= fin && (cls == C_MOVCO);
         branch_taken_q <= fin && is_br && result_nz;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_opcode;
      fetch_ok |=> opcode_q == $past(mem_rdata[15:8]) && field_b_q == $past(mem_rdata[3:0]);
   endproperty
   a_opcode: assert property (p_opcode) else $error("opcode field wrong");
   property p_sdisp;
      dec_go && frm == F_SDS |=> oper_addr_q == $past(reg_rd_data) + $past({12'h000, field_b_q});
   endproperty
   a_sdisp: assert property (p_sdisp) else $error("short displaced address wrong");
   property p_sdisp_reg;
      dec_go && frm == F_SDS |-> reg_rd_sel_q == SDISP_REG;
   endproperty
   a_sdisp_reg: assert property (p_sdisp_reg) else $error("base not register one");
   property p_imm;
      dec_go && frm == F_IMM |=> oper_addr_q == $past(pc_q) && pc_q == $past(pc_q) + 16'h0001;
   endproperty
   a_imm: assert property (p_imm) else $error("immediate handling wrong");
   property p_noidx;
      ext_ok && idx_sel == 3'h0 |=> oper_addr_q == $past(mem_rdata);
   endproperty
   a_noidx: assert property (p_noidx) else $error("index zero applied");
   property p_ext_only_dir;
      state_q == S_EXT |-> is_dir && reg_rd_sel_q < 4'h8;
   endproperty
   a_ext_only_dir: assert property (p_ext_only_dir) else $error("bad extension fetch");
   property p_done_time;
      $rose(done) && !illegal_q |-> elapsed_q >= need_cyc;
   endproperty
   a_done_time: assert property (p_done_time) else $error("done before step count");
   property p_branch;
      branch_taken_q |-> done && is_br && $past(result_nz);
   endproperty
   a_branch: assert property (p_branch) else $error("branch without nonzero");
   property p_cmp;
      done && cls == C_CMP |-> !wr_reg_q && !wr_mem_q && (cond_upd_q || illegal_q);
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare altered operand");
   property p_byte;
      done && (cls == C_LBYTE || cls == C_SBYTE) && !illegal_q |-> $onehot(byte_en_q);
   endproperty
   a_byte: assert property (p_byte) else $error("byte lane not single");
   property p_done_pulse;
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");

   c_indirect: cover property (ind_ok ##[1:1000] done);
   c_file: cover property (done && is_file && word_count_q == 4'h8);
   c_branch: cover property (branch_taken_q);
   c_illegal: cover property (illegal_q);
endmodule

// file: hw/instr_decode_pkg.sv
/*
 Constants, field layout, opcode classes and forms, and execution
 times of the instruction format and address decoder.
 Assumes a 100 MHz core clock; bit 0 of a documented word is our bit 15.
*/
package instr_decode_pkg;
   typedef logic [15:0] word_t;
   typedef logic [3:0]  nib_t;

   localparam int CLK_NS   = 10;
   localparam int STEP_NS  = 267;
   localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;

   localparam int T_0800_NS = 800;
   localparam int T_1600_NS = 1600;
   localparam int T_1870_NS = 1870;
   localparam int T_2130_NS = 2130;
   localparam int T_2400_NS = 2400;
   localparam int T_2930_NS = 2930;
   localparam int T_3470_NS = 3470;
   localparam int T_3830_NS = 3830;
   localparam int T_4270_NS = 4270;
   localparam int T_4800_NS = 4800;
   localparam int T_6130_NS = 6130;
   localparam int T_6670_NS = 6670;
   localparam int T_7200_NS = 7200;
   localparam int T_8800_NS = 8800;
   localparam int T_9330_NS = 9330;
   localparam int T_9870_NS = 9870;
   localparam int T_WORD_NS = 800;

   localparam word_t PC_RST     = 16'h0000;
   localparam nib_t  SDISP_REG  = 4'h1;
   localparam int    MAX_WORDS  = 8;

   typedef enum logic [3:0] {
      C_LOAD = 4'h0, C_STORE = 4'h1, C_LFILE = 4'h2, C_SFILE = 4'h3,
      C_LBYTE = 4'h4, C_SBYTE = 4'h5, C_MOVE = 4'h6, C_ADDM = 4'h7,
      C_ADD2M = 4'h8, C_DADD = 4'h9, C_SUB = 4'hA, C_MUL = 4'hB,
      C_DIV = 4'hC, C_CMP = 4'hD, C_MOVCO = 4'hE, C_NEG = 4'hF
   } cls_t;

   typedef enum logic [3:0] {
      F_DIR = 4'h0, F_IMM = 4'h1, F_SDS = 4'h2, F_SIX = 4'h3,
      F_RR = 4'h4, F_RRB = 4'h5, F_DIRB = 4'h6, F_SDSB = 4'h7,
      F_SIXB = 4'h8
   } form_t;

   function automatic logic [5:0] to_steps(input int ns);
      return 6'((2 * ns + STEP_NS) / (2 * STEP_NS));
   endfunction
endpackage

// file: sim/core_mem_model.sv
/*
 Word-wide core memory answering the decoder's read requests.
 Assumes mem_req is held until mem_ack; the bench fills mem directly.
*/
`timescale 1ns/1ps
module core_mem_model (
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire logic                    mem_req,
   input  wire instr_decode_pkg::word_t mem_addr_q,
   input  wire logic [1:0]              lag,
   output logic                         mem_ack,
   output instr_decode_pkg::word_t      mem_rdata
);
   import instr_decode_pkg::*;

   word_t      mem [0:65535];
   word_t      last_q;
   logic [1:0] wait_q;

   // Slow answers come after lag waiting cycles
   assign mem_ack = mem_req && (wait_q == lag);

   // Released bus shows the inverse of the last word, never a stale match
   always_comb begin
      mem_rdata = mem_ack ? mem[mem_addr_q] : ~last_q;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 2'h0;
         last_q <= 16'h0000;
      end else if (mem_ack) begin
         wait_q <= 2'h0;
         last_q <= mem[mem_addr_q];
      end else if (mem_req) begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// file: sim/tb_top.sv
/*
 Self-checking bench for the instruction format and address decoder.
 Assumes the core memory model on the far side; registers are a bench array.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   import instr_decode_pkg::*;

   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       start = 1'b0;
   logic       pc_load = 1'b0;
   word_t      pc_load_val = 16'h0000;
   logic       result_nz = 1'b0;
   word_t      branch_target = 16'h0000;
   nib_t       file_words = 4'h1;
   logic [1:0] lag = 2'h0;
   logic       mem_ack, mem_req, busy, done;
   word_t      mem_rdata, reg_rd_data, mem_addr_q, oper_addr_q, pc_q;
   nib_t       reg_rd_sel_q, field_a_q, field_b_q, word_count_q;
   logic [7:0] opcode_q;
   logic [1:0] byte_en_q;
   logic       illegal_q, wr_reg_q, wr_mem_q, cond_upd_q, clear_ovf_q, branch_taken_q;
   word_t      regs [0:15];
   int         error_cnt = 0;
   int         n_compared = 0;
   int         seq = 0;

   always #5 clk = ~clk;
   assign reg_rd_data = regs[reg_rd_sel_q];

   instr_format_addr_decoder u_instr_format_addr_decoder (
      .clk(clk), .rst_b(rst_b), .start(start), .pc_load(pc_load),
      .pc_load_val(pc_load_val), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .reg_rd_data(reg_rd_data), .result_nz(result_nz), .branch_target(branch_target),
      .file_words(file_words), .mem_req(mem_req), .mem_addr_q(mem_addr_q),
      .reg_rd_sel_q(reg_rd_sel_q), .busy(busy), .done(done), .opcode_q(opcode_q),
      .field_a_q(field_a_q), .field_b_q(field_b_q), .oper_addr_q(oper_addr_q),
      .pc_q(pc_q), .word_count_q(word_count_q), .byte_en_q(byte_en_q),
      .illegal_q(illegal_q), .wr_reg_q(wr_reg_q), .wr_mem_q(wr_mem_q),
      .cond_upd_q(cond_upd_q), .clear_ovf_q(clear_ovf_q),
      .branch_taken_q(branch_taken_q));

   core_mem_model u_core_mem_model (
      .clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_addr_q(mem_addr_q),
      .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   task automatic conclude();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One instruction at a fresh pc; st < 0 expects a refusal as illegal
   task automatic exec(input logic [7:0] op, input nib_t b, input int st,
                       input nib_t fw, input logic nz);
      word_t      pc0, ext, ix, ea, exp_oa, exp_pc;
      form_t      f;
      cls_t       c;
      logic       br, wm, bt;
      logic [1:0] be;
      nib_t       wc;
      int         n;
      f = form_t'(op[3:0]);
      c = cls_t'(op[7:4]);
      pc0 = 16'h0100 + 16'(seq * 4);
      ext = 16'h4000 + 16'(seq * 4);
      ix = (b[2:0] != 3'h0) ? regs[b[2:0]] : 16'h0000;
      ea = ext + ix;
      u_core_mem_model.mem[pc0] = {op, 4'h2, b};
      u_core_mem_model.mem[pc0 + 16'h1] = ext;
      u_core_mem_model.mem[ea] = ~ea;
      bt = (c == C_LBYTE) || (c == C_SBYTE);
      case (f)
         F_DIR, F_DIRB: exp_oa = b[3] ? ~ea : ea;
         F_IMM:         exp_oa = pc0 + 16'h1;
         F_SDS, F_SDSB: exp_oa = regs[1] + 16'(b);
         default:       exp_oa = bt ? regs[b] >> 1 : regs[b];
      endcase
      be = bt ? (regs[b][0] ? 2'b01 : 2'b10) : 2'b11;
      br = (f == F_RRB || f == F_DIRB || f == F_SDSB || f == F_SIXB) && nz;
      exp_pc = pc0 + ((f == F_DIR || f == F_DIRB || f == F_IMM) ? 16'h2 : 16'h1);
      if (br)
         exp_pc = ~pc0;
      wm = (c == C_STORE) || (c == C_SFILE) || (c == C_SBYTE) || (c == C_ADD2M);
      // Word counts outside one to eight are clamped, not refused
      wc = (fw == 4'h0) ? 4'h1 : (fw > 4'(MAX_WORDS)) ? 4'(MAX_WORDS) : fw;
      if (c != C_LFILE && c != C_SFILE)
         wc = 4'h1;
      @(posedge clk);
      pc_load <= 1'b1;
      pc_load_val <= pc0;
      file_words <= fw;
      result_nz <= nz;
      branch_target <= ~pc0;
      lag <= 2'(seq);
      @(posedge clk);
      pc_load <= 1'b0;
      start <= 1'b1;
      @(posedge clk);
      // Cycle after the start edge is the first busy cycle
      n = 1;
      // Start stays up one extra edge; the busy decoder must ignore it
      do begin
         @(posedge clk);
         start <= 1'b0;
         n++;
         #1;
      end while (done !== 1'b1 && n < 2000);
      `CHK("done_seen", 1'b1, done)
      seq++;
      if (st < 0) begin
         `CHK("illegal", 1'b1, illegal_q)
         `CHK("ill_writes", 2'b00, {wr_reg_q, wr_mem_q})
         `CHK("ill_pc", pc0 + 16'h1, pc_q)
      end else begin
         `CHK("cycles", st * STEP_CYC, n)
         `CHK("opcode", op, opcode_q)
         `CHK("fields", {4'h2, b}, {field_a_q, field_b_q})
         if (f != F_RR && f != F_RRB)
            `CHK("oper_addr", exp_oa, oper_addr_q)
         `CHK("pc", exp_pc, pc_q)
         `CHK("branch", br, branch_taken_q)
         `CHK("writes", {!wm && c != C_CMP, wm}, {wr_reg_q, wr_mem_q})
         if (c == C_CMP)
            `CHK("cond_upd", 1'b1, cond_upd_q)
         `CHK("clr_ovf", c == C_MOVCO, clear_ovf_q)
         `CHK("words", wc, word_count_q)
         `CHK("byte_en", be, byte_en_q)
      end
      @(posedge clk);
      #1;
      `CHK("done_pulse", 2'b00, {done, busy})
   endtask

   initial begin
      // About twice the expected run
      #300_000;
      error_cnt++;
      conclude();
   end

   initial begin
      for (int k = 0; k < 16; k++)
         regs[k] = 16'h1111 * 16'(k);
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("rst_pc", PC_RST, pc_q)
      `CHK("rst_flags", 4'b1100, {byte_en_q, busy, done})
      exec(8'h00, 4'h6, 9, 4'h1, 1'b0);
      exec(8'h00, 4'hB, 9, 4'h1, 1'b0);
      exec(8'h10, 4'h0, 9, 4'h1, 1'b0);
      exec(8'h01, 4'h6, 6, 4'h1, 1'b0);
      exec(8'h02, 4'hF, 7, 4'h1, 1'b0);
      exec(8'h13, 4'h6, 7, 4'h1, 1'b0);
      exec(8'h20, 4'h0, 32, 4'h8, 1'b0);
      exec(8'h22, 4'h6, 9, 4'h1, 1'b0);
      exec(8'h30, 4'h0, 28, 4'h8, 1'b0);
      exec(8'h33, 4'h6, 13, 4'h3, 1'b0);
      exec(8'h23, 4'h6, 30, 4'hC, 1'b0);
      exec(8'h32, 4'h6, 7, 4'h0, 1'b0);
      exec(8'h43, 4'h3, 8, 4'h1, 1'b0);
      exec(8'h53, 4'h6, 9, 4'h1, 1'b0);
      exec(8'h64, 4'h6, 3, 4'h1, 1'b0);
      exec(8'h65, 4'h6, 6, 4'h1, 1'b1);
      exec(8'h65, 4'h6, 6, 4'h1, 1'b0);
      exec(8'h70, 4'h6, 9, 4'h1, 1'b0);
      exec(8'h71, 4'h6, 6, 4'h1, 1'b0);
      exec(8'h72, 4'h6, 7, 4'h1, 1'b0);
      exec(8'h74, 4'h6, 3, 4'h1, 1'b0);
      exec(8'h75, 4'h6, 6, 4'h1, 1'b1);
      exec(8'h80, 4'h6, 13, 4'h1, 1'b0);
      exec(8'h86, 4'h6, 16, 4'h1, 1'b1);
      exec(8'h82, 4'h6, 11, 4'h1, 1'b0);
      exec(8'h87, 4'h6, 14, 4'h1, 1'b0);
      exec(8'h88, 4'h6, 14, 4'h1, 1'b1);
      exec(8'h94, 4'h6, 6, 4'h1, 1'b0);
      exec(8'hA0, 4'h6, 9, 4'h1, 1'b0);
      exec(8'hA1, 4'h6, 6, 4'h1, 1'b0);
      exec(8'hA2, 4'h6, 6, 4'h1, 1'b0);
      exec(8'hA3, 4'h6, 7, 4'h1, 1'b0);
      exec(8'hA4, 4'h6, 3, 4'h1, 1'b0);
      exec(8'hA5, 4'h6, 6, 4'h1, 1'b0);
      exec(8'hB0, 4'h6, 27, 4'h1, 1'b0);
      exec(8'hB2, 4'h6, 25, 4'h1, 1'b0);
      exec(8'hB4, 4'h6, 23, 4'h1, 1'b0);
      exec(8'hC0, 4'h6, 37, 4'h1, 1'b0);
      exec(8'hC3, 4'h6, 35, 4'h1, 1'b0);
      exec(8'hC4, 4'h6, 33, 4'h1, 1'b0);
      exec(8'hD0, 4'h6, 18, 4'h1, 1'b0);
      exec(8'hD2, 4'h6, 16, 4'h1, 1'b0);
      exec(8'hE4, 4'h6, 3, 4'h1, 1'b0);
      exec(8'hF4, 4'h6, 3, 4'h1, 1'b0);
      exec(8'hF5, 4'h6, 6, 4'h1, 1'b1);
      exec(8'h0F, 4'h6, -1, 4'h1, 1'b0);
      exec(8'h09, 4'h6, -1, 4'h1, 1'b0);
      conclude();
   end
endmodule
